// ===== shared/agd_defs.svh
// Offsets, field positions, reset values and timing counts of the block.
// Contract
// - Sequencing bit in mode 3 drives mapped pins.
// - Otherwise mode 3 pins follow direct registers.
// - Modes 1 and 2 ignore sequencing bit.
// - Sync enable bit turns sync mode on/off.
// - Readback bit picks interface or internal coefficient.
// - Skip system gain drops that coefficient.
// - Skip system offset drops that coefficient.
// - Skip self gain drops that coefficient.
// - Skip self offset drops that coefficient.
// - Pin 1 select: one GPIO, zero sync.
// - Pin 0 select: one GPIO, zero clock; resets one.
// - Direction bits: one output, zero input; reset input.
// - Output pins drive their data bit.
// - Input pins read back pin level.
// - Mux delay counts 4 us per step.
// - Output delay counts 20 us per step.
// - Channel map pairs channels with driven pins.
// - External clock bit makes pin 0 clock.
`ifndef AGD_DEFS_SVH
`define AGD_DEFS_SVH

// Register access port geometry.
`define AGD_ADDR_W 5
`define AGD_DATA_W 24

// Register addresses on the serial register port.
`define AGD_ADDR_CTRL 5'h03
`define AGD_ADDR_GPIO 5'h04
`define AGD_ADDR_DELAY 5'h05
`define AGD_ADDR_COEF0 5'h10
`define AGD_ADDR_COEF3 5'h13

// Conversion and calibration control fields.
`define AGD_CTRL_OSEL 6
`define AGD_CTRL_SYNC 5
`define AGD_CTRL_RBSEL 4
`define AGD_CTRL_NSG 3
`define AGD_CTRL_NSO 2
`define AGD_CTRL_NCG 1
`define AGD_CTRL_NCO 0
`define AGD_CTRL_RST 8'h1C

// General pin control fields.
`define AGD_GPIO_FS1 7
`define AGD_GPIO_FS0 6
`define AGD_GPIO_DIR_HI 3
`define AGD_GPIO_DIR_LO 2
`define AGD_GPIO_FS_RST 2'h1

// Sequencer mode that allows automatic pin sequencing.
`define AGD_SEQ_MODE3 2'h3

// Channel map entry layout, seven bits per channel.
`define AGD_CH_W 7
`define AGD_CH_LAST 3'h5
`define AGD_CH_GPOEN 0
`define AGD_CH_EN 1

// Settling step times and the clock rate.
`define AGD_CLK_MHZ 200
`define AGD_MUX_STEP_US 4
`define AGD_GPO_STEP_US 20
`define AGD_MUX_STEP_CYC (`AGD_MUX_STEP_US * `AGD_CLK_MHZ)
`define AGD_GPO_STEP_CYC (`AGD_GPO_STEP_US * `AGD_CLK_MHZ)

`endif

// ===== shared/agd_pkg.sv
// Types shared by the pin, register and delay logic.
package agd_pkg;

  // Settling timer states.
  typedef enum logic {AGD_TMR_IDLE, AGD_TMR_RUN} agd_tmr_state_e;

  // One calibration coefficient word.
  typedef logic [23:0] agd_coef_t;

endpackage : agd_pkg

// ===== rtl/agd_step_timer.sv
// Settling delay timer counting a programmed number of fixed steps.
`timescale 1ns/1ps
`include "agd_defs.svh"
module agd_step_timer
  import agd_pkg::*;
#(
  parameter int STEP_CYC = 800
)
(
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Start request and its step count.
  input wire logic start_i,
  input wire logic [7:0] count_i,
  // Delay in progress.
  output logic busy_o
);

  localparam int PW = $clog2(STEP_CYC + 1);

  agd_tmr_state_e state; // Current timer state.
  logic [PW-1:0] pre; // Cycles left in the present step.
  logic [7:0] steps; // Steps left including the present one.
  wire pre_done = (pre == '0);

  // A new start always restarts, so a second change extends the delay.
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      state <= AGD_TMR_IDLE;
      pre <= '0;
      steps <= 8'h00;
    end
    else if (start_i)
    begin
      // A zero count means no delay at all.
      state <= (count_i == 8'h00) ? AGD_TMR_IDLE : AGD_TMR_RUN;
      steps <= count_i;
      pre <= PW'(STEP_CYC - 1);
    end
    else
    begin
      case (state)
        AGD_TMR_RUN:
        begin
          // Each step lasts exactly STEP_CYC cycles.
          if (pre_done)
          begin
            pre <= PW'(STEP_CYC - 1);
            steps <= steps - 8'h01;
            if (steps == 8'h01)
            begin
              state <= AGD_TMR_IDLE;
            end
          end
          else
          begin
            pre <= pre - PW'(1);
          end
        end
        default:
        begin
          state <= AGD_TMR_IDLE;
        end
      endcase
    end
  end

  assign busy_o = (state == AGD_TMR_RUN);

  // Helper: length of the current busy stretch and the count it began with.
  int run_cyc;
  int run_steps;
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i || start_i)
    begin
      run_cyc <= 0;
      run_steps <= int'(count_i);
    end
    else if (busy_o)
    begin
      run_cyc <= run_cyc + 1;
    end
  end

  // A nonzero start makes the timer busy on the next edge.
  start_busy_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    start_i && count_i != 8'h00 |=> busy_o)
    else $error("timer not busy after nonzero start");

  // A zero start means no delay.
  zero_idle_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    start_i && count_i == 8'h00 |=> !busy_o)
    else $error("timer busy after zero start");

  // An uninterrupted delay lasts count times the step length.
  delay_len_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    $fell(busy_o) && !$past(start_i) |->
      run_cyc == run_steps * STEP_CYC)
    else $error("settling delay has wrong length");

endmodule : agd_step_timer

// ===== rtl/agd_regs.sv
// Control, general pin and settling delay registers with pin sequencing.
`timescale 1ns/1ps
`include "agd_defs.svh"
module agd_regs
  import agd_pkg::*;
#(
  parameter int MUX_STEP_CYC = `AGD_MUX_STEP_CYC,
  parameter int GPO_STEP_CYC = `AGD_GPO_STEP_CYC
)
(
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Decoded register accesses from the serial interface.
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [`AGD_ADDR_W-1:0] reg_addr_i,
  input wire logic [`AGD_DATA_W-1:0] reg_wdata_i,
  output logic [`AGD_DATA_W-1:0] reg_rdata_o,
  output logic reg_rvalid_o,
  // Calibration coefficients, interface copy and internal copy.
  input wire agd_coef_t [3:0] coef_iface_i,
  input wire agd_coef_t [3:0] coef_internal_i,
  // Scan sequencer state and neighbouring registers.
  input wire logic [1:0] seq_mode_i,
  input wire logic converting_i,
  input wire logic [2:0] channel_i,
  input wire logic [41:0] channel_map_i,
  input wire logic [1:0] output_direct_control_i,
  input wire logic external_clock_enable_i,
  // Dual-purpose pins and general outputs.
  input wire logic [1:0] gpio_in_i,
  output logic [1:0] gpio_out_o,
  output logic [1:0] gpio_oe_o,
  output logic [1:0] gpo_o,
  // Function controls towards the converter.
  output logic sync_enable_o,
  output logic sync_pin_o,
  output logic clk_pin_input_o,
  output logic use_system_gain_o,
  output logic use_system_offset_o,
  output logic use_self_gain_o,
  output logic use_self_offset_o,
  output logic settle_busy_o
);

  // Pick one channel's seven-bit entry; channels past the last read empty.
  function automatic logic [6:0] chan_entry(input logic [41:0] map,
                                            input logic [2:0] ch);
    chan_entry = (ch > `AGD_CH_LAST) ? 7'h00 : map[ch * `AGD_CH_W +: 7];
  endfunction : chan_entry

  // Decode a two-bit pin code into GPO0, GPO1, GPIO0, GPIO1 one-hot.
  function automatic logic [3:0] pin_onehot(input logic [1:0] code);
    pin_onehot = 4'h1 << code;
  endfunction : pin_onehot

  // Register state.
  logic [7:0] conversion_cal_control; // Conversion and calibration control.
  logic pin1_function_select; // One makes pin 1 general purpose.
  logic pin0_function_select; // One makes pin 0 general purpose.
  logic [1:0] pin_dir; // One means output.
  logic [1:0] pin_value; // Output latch of the data bits.
  logic [15:0] settling_delay; // Mux delay high byte, output delay low.

  // Pin input synchroniser, three stages and a settled level.
  logic [1:0] pin_s1;
  logic [1:0] pin_s2;
  logic [1:0] pin_s3;
  logic [1:0] pin_stable;

  // Previous channel, to see a channel switch.
  logic [2:0] chan_q;

  // Write strobes per register and the coefficient read decode.
  wire wr_ctrl = reg_wr_i && (reg_addr_i == `AGD_ADDR_CTRL);
  wire wr_gpio = reg_wr_i && (reg_addr_i == `AGD_ADDR_GPIO);
  wire wr_delay = reg_wr_i && (reg_addr_i == `AGD_ADDR_DELAY);
  wire rd_coef = (reg_addr_i >= `AGD_ADDR_COEF0) &&
                 (reg_addr_i <= `AGD_ADDR_COEF3);
  wire [1:0] coef_idx = reg_addr_i[1:0];

  // Named control bits.
  wire osel = conversion_cal_control[`AGD_CTRL_OSEL];
  wire rbsel = conversion_cal_control[`AGD_CTRL_RBSEL];

  // Automatic sequencing only in mode 3; modes 1 and 2 never look at it.
  wire seq_auto = (seq_mode_i == `AGD_SEQ_MODE3) && osel;

  // Entry of the selected channel and the pin it activates.
  wire [6:0] entry = chan_entry(channel_map_i, channel_i);
  wire entry_on = converting_i && entry[`AGD_CH_EN] &&
                  entry[`AGD_CH_GPOEN];
  wire [3:0] auto_pins = entry_on ? pin_onehot(entry[6:5]) : 4'h0;

  // Pin 0 is general purpose only when selected and not the clock input.
  wire [1:0] is_gpio;
  assign is_gpio[1] = pin1_function_select;
  assign is_gpio[0] = pin0_function_select &&
                      !external_clock_enable_i;

  // Next pin drive, automatic or from the direct registers.
  wire [1:0] next_gpo = seq_auto ? auto_pins[1:0]
                                 : output_direct_control_i;
  wire [1:0] next_gpio_oe = seq_auto ? is_gpio
                                     : (is_gpio & pin_dir);
  wire [1:0] next_gpio_out = seq_auto ? auto_pins[3:2]
                                      : pin_value;

  // Data bits read back the latch on outputs, the pin level on inputs.
  wire [1:0] out_bits = is_gpio & pin_dir;
  wire [1:0] pin_read = (out_bits & pin_value) |
                        (~out_bits & pin_stable);
  wire [7:0] gpio_read = {pin1_function_select, pin0_function_select,
                          2'h0, pin_dir, pin_read};

  // Delay starts: any channel switch, any driven pin change.
  wire mux_start = (channel_i != chan_q);
  wire gpo_start = ({next_gpo, next_gpio_out, next_gpio_oe} !=
                    {gpo_o, gpio_out_o, gpio_oe_o});
  wire mux_busy;
  wire gpo_busy;

  // Read data selection; unmapped addresses read as zero.
  wire [`AGD_DATA_W-1:0] next_rdata =
    (reg_addr_i == `AGD_ADDR_CTRL) ? {16'h0000, conversion_cal_control} :
    (reg_addr_i == `AGD_ADDR_GPIO) ? {16'h0000, gpio_read} :
    (reg_addr_i == `AGD_ADDR_DELAY) ? {8'h00, settling_delay} :
    (rd_coef && rbsel) ? coef_iface_i[coef_idx] :
    rd_coef ? coef_internal_i[coef_idx] :
    24'h000000;

  // Control register; its reset value sets sync and sequencing off.
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      conversion_cal_control <= `AGD_CTRL_RST;
    end
    else if (wr_ctrl)
    begin
      // The top bit is reserved and stays zero.
      conversion_cal_control <= {1'b0, reg_wdata_i[6:0]};
    end
  end

  // Pin control register; data bits hold the output latch.
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      {pin1_function_select, pin0_function_select} <=
        `AGD_GPIO_FS_RST;
      pin_dir <= 2'h0;
      pin_value <= 2'h0;
    end
    else if (wr_gpio)
    begin
      pin1_function_select <= reg_wdata_i[`AGD_GPIO_FS1];
      pin0_function_select <= reg_wdata_i[`AGD_GPIO_FS0];
      pin_dir <= reg_wdata_i[`AGD_GPIO_DIR_HI:`AGD_GPIO_DIR_LO];
      pin_value <= reg_wdata_i[1:0];
    end
  end

  // Delay register, mux field above the output field.
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      settling_delay <= 16'h0000;
    end
    else if (wr_delay)
    begin
      settling_delay <= reg_wdata_i[15:0];
    end
  end

  // Read answer one cycle after the strobe.
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      reg_rdata_o <= 24'h000000;
      reg_rvalid_o <= 1'b0;
    end
    else
    begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i)
      begin
        reg_rdata_o <= next_rdata;
      end
    end
  end

  // Pin synchroniser; only the second stage reads the first, and a level
  // is taken once stages two and three agree so a glitch is not seen.
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      pin_s1 <= 2'h0;
      pin_s2 <= 2'h0;
      pin_s3 <= 2'h0;
      pin_stable <= 2'h0;
    end
    else
    begin
      pin_s1 <= gpio_in_i;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin_stable <= (pin_s2 & pin_s3) | (pin_stable & (pin_s2 | pin_s3));
    end
  end

  // Registered pin drive and channel history.
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      gpo_o <= 2'h0;
      gpio_out_o <= 2'h0;
      gpio_oe_o <= 2'h0;
      chan_q <= 3'h0;
    end
    else
    begin
      gpo_o <= next_gpo;
      gpio_out_o <= next_gpio_out;
      gpio_oe_o <= next_gpio_oe;
      chan_q <= channel_i;
    end
  end

  // Function outputs from the control bits, the settled pin level and the delay timers.
  assign sync_enable_o = conversion_cal_control[`AGD_CTRL_SYNC];
  assign sync_pin_o = !pin1_function_select && pin_stable[1];
  assign clk_pin_input_o = external_clock_enable_i ||
                           !pin0_function_select;
  assign use_system_gain_o = !conversion_cal_control[`AGD_CTRL_NSG];
  assign use_system_offset_o = !conversion_cal_control[`AGD_CTRL_NSO];
  assign use_self_gain_o = !conversion_cal_control[`AGD_CTRL_NCG];
  assign use_self_offset_o = !conversion_cal_control[`AGD_CTRL_NCO];
  assign settle_busy_o = mux_busy || gpo_busy;

  // Mux settling, 4 us steps.
  agd_step_timer #(.STEP_CYC(MUX_STEP_CYC)) u_mux_tmr (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .start_i(mux_start),
    .count_i(settling_delay[15:8]),
    .busy_o(mux_busy)
  );

  // Output pin settling, 20 us steps.
  agd_step_timer #(.STEP_CYC(GPO_STEP_CYC)) u_gpo_tmr (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .start_i(gpo_start),
    .count_i(settling_delay[7:0]),
    .busy_o(gpo_busy)
  );

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  // A control write strobe alone; the properties check its effect.
  sequence ctrl_write;
    wr_ctrl;
  endsequence

  sequence coef_read;
    reg_rd_i && rd_coef;
  endsequence

  seq_drive_a: assert property (seq_mode_i == `AGD_SEQ_MODE3 && osel &&
    entry_on |=> gpo_o == $past(auto_pins[1:0]))
    else $error("sequenced output pin not driven");

  direct_drive_a: assert property (!seq_auto |=>
    gpo_o == $past(output_direct_control_i))
    else $error("direct output control not followed");

  mode12_ignore_a: assert property (seq_mode_i != `AGD_SEQ_MODE3 |=>
    gpo_o == $past(output_direct_control_i) &&
    gpio_oe_o == $past(is_gpio & pin_dir))
    else $error("sequencing bit acted outside mode 3");

  sync_bit_a: assert property (ctrl_write |=>
    sync_enable_o == $past(reg_wdata_i[`AGD_CTRL_SYNC]))
    else $error("sync enable does not follow write");

  coef_back_a: assert property (coef_read |=> reg_rvalid_o &&
    reg_rdata_o == ($past(rbsel) ? $past(coef_iface_i[coef_idx])
                                 : $past(coef_internal_i[coef_idx])))
    else $error("wrong coefficient copy read back");

  skip_bits_a: assert property (ctrl_write |=>
    {use_system_gain_o, use_system_offset_o, use_self_gain_o,
     use_self_offset_o} == ~$past(reg_wdata_i[3:0]))
    else $error("coefficient use does not follow skip bits");

  pin1_sync_a: assert property (!pin1_function_select |=>
    !gpio_oe_o[1])
    else $error("sync pin driven");

  pin0_clock_a: assert property ((!pin0_function_select ||
    external_clock_enable_i) |=> !gpio_oe_o[0])
    else $error("clock pin driven");

  out_drive_a: assert property (!seq_auto && is_gpio[0] && pin_dir[0] |=>
    gpio_oe_o[0] && gpio_out_o[0] == $past(pin_value[0]))
    else $error("output pin not driven from data bit");

  in_read_a: assert property (reg_rd_i && reg_addr_i == `AGD_ADDR_GPIO &&
    !pin_dir[1] |=> reg_rdata_o[1] == $past(pin_stable[1]))
    else $error("input pin level not read back");

  ctrl_reset_a: assert property (disable iff (1'b0) rst_i |=>
    conversion_cal_control == `AGD_CTRL_RST)
    else $error("control register reset value wrong");

  chan_delay_a: assert property (mux_start &&
    settling_delay[15:8] != 8'h00 |=> settle_busy_o)
    else $error("channel switch did not start delay");

endmodule : agd_regs

// ===== verification/agd_pin_model.sv
// Pin-side model that resolves the two shared pins seen by the block.
`timescale 1ns/1ps
module agd_pin_model
(
  // Clock.
  input wire logic clk_i,
  // Block side of the pins.
  input wire logic [1:0] out_i,
  input wire logic [1:0] oe_i,
  // Far-side drivers.
  input wire logic [1:0] drv_i,
  input wire logic [1:0] drv_en_i,
  // Resolved pin levels.
  output logic [1:0] level_o
);
  // Pattern shown on a pin that nobody drives.
  logic [1:0] float_pat = 2'h0;

  // The pattern toggles so that a floating pin never reads as steady.
  always @(posedge clk_i)
  begin
    float_pat <= ~float_pat;
  end

  // The block wins where it drives, then the far side, else it floats.
  assign level_o = (oe_i & out_i) | (~oe_i & drv_en_i & drv_i)
                 | (~oe_i & ~drv_en_i & float_pat);
endmodule : agd_pin_model

// ===== verification/agd_regs_bench.sv
// Self-checking bench for the control, pin and settling delay registers.
`timescale 1ns/1ps
`include "agd_defs.svh"
module agd_regs_bench
  import agd_pkg::*;
;
  // Short step counts keep the delay checks brief.
  localparam int MUX = 4;
  localparam int GPO = 10;

  // Clock, reset and register port.
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [4:0] reg_addr_i = 5'h00;
  logic [23:0] reg_wdata_i = 24'h000000;
  logic [23:0] reg_rdata_o;
  logic reg_rvalid_o;
  // Coefficient copies, distinct so a wrong pick shows.
  agd_coef_t [3:0] coef_iface = {24'hA00003, 24'hA00002, 24'hA00001,
                                 24'hA00000};
  agd_coef_t [3:0] coef_int = {24'hB00003, 24'hB00002, 24'hB00001,
                               24'hB00000};
  // Sequencer side inputs.
  logic [1:0] seq_mode_i = 2'h1;
  logic converting_i = 1'b0;
  logic [2:0] channel_i = 3'h0;
  logic [41:0] channel_map_i = 42'h0;
  logic [1:0] output_direct_control_i = 2'h0;
  logic external_clock_enable_i = 1'b0;
  // Pins and function outputs.
  logic [1:0] pin_level;
  logic [1:0] gpio_out_o;
  logic [1:0] gpio_oe_o;
  logic [1:0] gpo_o;
  logic sync_enable_o;
  logic sync_pin_o;
  logic clk_pin_input_o;
  logic use_system_gain_o;
  logic use_system_offset_o;
  logic use_self_gain_o;
  logic use_self_offset_o;
  logic settle_busy_o;
  // Far-side pin drivers.
  logic [1:0] pin_drv = 2'h0;
  logic [1:0] pin_drv_en = 2'h3;
  // Counters of the run.
  int fails = 0;
  int checks_done = 0;

  // A 5 ns clock.
  always #2.5 ref_clk_i = ~ref_clk_i;

  agd_regs #(.MUX_STEP_CYC(MUX), .GPO_STEP_CYC(GPO)) dut (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .reg_rvalid_o(reg_rvalid_o), .coef_iface_i(coef_iface),
    .coef_internal_i(coef_int), .seq_mode_i(seq_mode_i),
    .converting_i(converting_i), .channel_i(channel_i),
    .channel_map_i(channel_map_i),
    .output_direct_control_i(output_direct_control_i),
    .external_clock_enable_i(external_clock_enable_i),
    .gpio_in_i(pin_level), .gpio_out_o(gpio_out_o),
    .gpio_oe_o(gpio_oe_o), .gpo_o(gpo_o), .sync_enable_o(sync_enable_o),
    .sync_pin_o(sync_pin_o), .clk_pin_input_o(clk_pin_input_o),
    .use_system_gain_o(use_system_gain_o),
    .use_system_offset_o(use_system_offset_o),
    .use_self_gain_o(use_self_gain_o),
    .use_self_offset_o(use_self_offset_o),
    .settle_busy_o(settle_busy_o));

  agd_pin_model pins (.clk_i(ref_clk_i), .out_i(gpio_out_o),
    .oe_i(gpio_oe_o), .drv_i(pin_drv), .drv_en_i(pin_drv_en),
    .level_o(pin_level));

  // Compares one value and reports a mismatch at once.
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One write pulse, then time for pins and synchronisers to settle.
  task automatic wr(input logic [4:0] a, input logic [23:0] d);
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
    repeat (6) @(posedge ref_clk_i);
    #1;
  endtask : wr

  // One read pulse; the answer stands only in the following cycle.
  task automatic rd(input logic [4:0] a, input logic [23:0] exp);
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    chk({23'h0, reg_rvalid_o}, 24'h1);
    chk(reg_rdata_o, exp);
  endtask : rd

  // Counts the cycles of one settling delay, zero if none starts.
  task automatic busy_len(output int n);
    int w;
    n = 0;
    w = 0;
    #1;
    while (settle_busy_o !== 1'b1 && w < 4)
    begin
      @(posedge ref_clk_i);
      #1;
      w++;
    end
    while (settle_busy_o === 1'b1 && n < 200)
    begin
      n++;
      @(posedge ref_clk_i);
      #1;
    end
  endtask : busy_len

  // Prints the end of one test.
  task automatic endtest(input string name);
    $display("Test %s done at %0t", name, $time);
  endtask : endtest

  // Prints the counts and the verdict, then stops.
  task automatic conclude();
    $display("Checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : conclude

  // A hang counts as a mismatch; the tests need well under this span.
  initial
  begin
    #40000;
    fails++;
    conclude();
  end

  // Main sequence of tests.
  initial
  begin
    int n;
    repeat (10) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    rd(`AGD_ADDR_CTRL, 24'h00001C); // Control reset.
    rd(`AGD_ADDR_GPIO, 24'h000040); // Pin reset.
    rd(`AGD_ADDR_DELAY, 24'h000000); // Delay reset.
    rd(5'h1F, 24'h000000); // Unmapped place reads zero.
    chk({use_system_gain_o, use_system_offset_o, use_self_gain_o,
      use_self_offset_o}, 24'h3); // Self used.
    chk(sync_enable_o, 24'h0); // Sync off.
    endtest("reset");
    // Each skip bit drops exactly its own coefficient.
    for (int b = 0; b < 4; b++)
    begin
      wr(`AGD_ADDR_CTRL, 24'(1 << b));
      chk({use_system_gain_o, use_system_offset_o, use_self_gain_o,
        use_self_offset_o}, 24'(4'hF ^ (1 << b)));
    end
    wr(`AGD_ADDR_CTRL, 24'h20);
    chk(sync_enable_o, 24'h1); // Sync on.
    wr(`AGD_ADDR_CTRL, 24'h10);
    rd(5'h11, 24'hA00001); // Interface copy.
    wr(`AGD_ADDR_CTRL, 24'h00);
    rd(5'h11, 24'hB00001); // Internal copy.
    chk(sync_enable_o, 24'h0); // Sync off again.
    endtest("control");
    @(posedge ref_clk_i);
    pin_drv <= 2'h1;
    wr(`AGD_ADDR_GPIO, 24'hC0);
    chk(gpio_oe_o, 24'h0); // Inputs undriven.
    rd(`AGD_ADDR_GPIO, 24'hC1); // Input levels read.
    wr(`AGD_ADDR_GPIO, 24'hCD);
    @(posedge ref_clk_i);
    pin_drv_en <= 2'h0;
    // Step off the edge so the registered pin drive is settled.
    #1;
    chk(gpio_oe_o, 24'h3); // Outputs driven.
    chk(gpio_out_o, 24'h1); // Data drives pins.
    rd(`AGD_ADDR_GPIO, 24'hCD); // Driven levels read.
    @(posedge ref_clk_i);
    pin_drv <= 2'h2;
    pin_drv_en <= 2'h3;
    wr(`AGD_ADDR_GPIO, 24'h0C);
    chk(gpio_oe_o, 24'h0); // Special inputs undriven.
    chk(sync_pin_o, 24'h1); // Pin 1 is the sync input.
    chk(clk_pin_input_o, 24'h1); // Pin 0 is the clock input.
    @(posedge ref_clk_i);
    external_clock_enable_i <= 1'b1;
    wr(`AGD_ADDR_GPIO, 24'hCC);
    chk(clk_pin_input_o, 24'h1); // Clock bit overrides.
    chk(gpio_oe_o, 24'h2); // Pin 0 released.
    chk(sync_pin_o, 24'h0); // Pin 1 is general.
    @(posedge ref_clk_i);
    external_clock_enable_i <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    #1;
    chk(clk_pin_input_o, 24'h0); // Pin 0 general.
    chk(gpio_oe_o, 24'h3); // Both pins driven.
    endtest("pins");
    @(posedge ref_clk_i);
    // Map set while idle: channel 2 pulses GPO1, channel 3 drives GPIO1.
    channel_map_i <= (42'(7'h63) << 21) | (42'(7'h23) << 14);
    seq_mode_i <= `AGD_SEQ_MODE3;
    converting_i <= 1'b1;
    channel_i <= 3'h2;
    output_direct_control_i <= 2'h1;
    wr(`AGD_ADDR_CTRL, 24'h40);
    chk(gpo_o, 24'h2); // Mapped pin active.
    // A GPIO pin code must reach the shared pins, not the GPO pins.
    @(posedge ref_clk_i);
    channel_i <= 3'h3;
    repeat (2) @(posedge ref_clk_i);
    #1;
    chk(gpio_out_o, 24'h2); // Mapped GPIO1 driven high.
    chk(gpo_o, 24'h0); // GPO pins idle for this channel.
    @(posedge ref_clk_i);
    channel_i <= 3'h2;
    wr(`AGD_ADDR_CTRL, 24'h00);
    chk(gpo_o, 24'h1); // Direct outputs.
    chk(gpio_out_o, 24'h0); // Pins follow their data bits.
    @(posedge ref_clk_i);
    seq_mode_i <= 2'h1;
    wr(`AGD_ADDR_CTRL, 24'h40);
    chk(gpo_o, 24'h1); // Sequencing bit ignored.
    endtest("sequencing");
    wr(`AGD_ADDR_DELAY, 24'h0300);
    rd(`AGD_ADDR_DELAY, 24'h000300); // Byte layout.
    @(posedge ref_clk_i);
    channel_i <= 3'h3;
    busy_len(n);
    chk(24'(n), 24'(3 * MUX)); // Mux delay length.
    wr(`AGD_ADDR_DELAY, 24'h0002);
    @(posedge ref_clk_i);
    output_direct_control_i <= 2'h2;
    busy_len(n);
    chk(24'(n), 24'(2 * GPO)); // Output delay length.
    wr(`AGD_ADDR_DELAY, 24'h0000);
    @(posedge ref_clk_i);
    channel_i <= 3'h4;
    busy_len(n);
    chk(24'(n), 24'h0); // Zero count gives no delay.
    endtest("delay");
    conclude();
  end
endmodule : agd_regs_bench
